// ===== warn_pkg.sv
// package: warning classes, code-line patterns, timing and register map of the warning encoder
package warn_pkg;

	// warning cause inputs, one bit each
	localparam int NUM_WARN = 19;
	localparam int W_POS_ERR = 0;      // position error overflow
	localparam int W_POS_ERR_SON = 1;  // position error overflow at servo on
	localparam int W_OVERLOAD = 2;
	localparam int W_VIBRATION = 3;
	localparam int W_REGEN = 4;
	localparam int W_DYN_BRAKE = 5;
	localparam int W_BATTERY = 6;
	localparam int W_DATA_SET0 = 7;    // five data-setting warnings: 7..11
	localparam int W_DATA_SET_N = 5;
	localparam int W_CMD0 = 12;        // five command warnings: 12..16
	localparam int W_CMD_N = 5;
	localparam int W_CMD_GAP = 2;      // third command code 95C is skipped, third and later warnings shift up
	localparam int W_COMM = 17;
	localparam int W_UNDERVOLT = 18;

	// code-line patterns {line2, line1, line0}, 1 = contact closed
	localparam logic [2:0] CODE_NONE = 3'h0;
	localparam logic [2:0] CODE_POS = 3'h0;
	localparam logic [2:0] CODE_OVL = 3'h1;
	localparam logic [2:0] CODE_REG = 3'h2;
	localparam logic [2:0] CODE_BAT = 3'h3;
	localparam logic [2:0] CODE_DATA = 3'h4;
	localparam logic [2:0] CODE_CMD = 3'h5;
	localparam logic [2:0] CODE_COMM = 3'h6;
	localparam logic [2:0] CODE_UV = 3'h7;
	localparam logic [2:0] CODE_MOD = 3'h1;

	// status query reply codes, display code digits as hex (warning 971 -> 12'h971)
	localparam logic [11:0] QC_NONE = 12'h000;
	localparam logic [11:0] QC_POS = 12'h900;
	localparam logic [11:0] QC_POS_SON = 12'h901;
	localparam logic [11:0] QC_OVL = 12'h910;
	localparam logic [11:0] QC_VIB = 12'h911;
	localparam logic [11:0] QC_REG = 12'h920;
	localparam logic [11:0] QC_DB = 12'h921;
	localparam logic [11:0] QC_BAT = 12'h930;
	localparam logic [11:0] QC_DATA0 = 12'h94A;
	localparam logic [11:0] QC_CMD0 = 12'h95A;
	localparam logic [11:0] QC_COMM = 12'h960;
	localparam logic [11:0] QC_UV = 12'h971;
	localparam logic [11:0] QC_MOD = 12'hA9F;
	localparam logic [11:0] QC_VIB_ALARM = 12'h520;

	// module error hold time
	localparam int HOLD_MS = 2000;
	localparam int CLK_KHZ = 50000;
	localparam int HOLD_CYC = HOLD_MS * CLK_KHZ;

	// indicator flash period (half period in cycles)
	localparam int FLASH_HALF_MS = 250;
	localparam int FLASH_HALF_CYC = FLASH_HALF_MS * CLK_KHZ;

	// register map (word addresses on the plain port)
	localparam logic [3:0] A_CONFIG = 4'h0;  // bit0 code sel, bit1 detect off, bit2 vib alarm
	localparam logic [3:0] A_STATUS = 4'h1;  // sticky events, read clears
	localparam logic [3:0] A_MASK = 4'h2;
	localparam logic [3:0] A_QUERY = 4'h3;   // alarm/warning reply
	localparam logic [3:0] A_LAST_ERR = 4'h4;
	localparam logic [3:0] A_LINES = 4'h5;
	localparam int CFG_CODE_SEL = 0;
	localparam int CFG_DET_OFF = 1;
	localparam int CFG_VIB_ALM = 2;
	localparam logic [2:0] CONFIG_RST = 3'h0;
	localparam logic [3:0] MASK_RST = 4'h0;
	// status event bits
	localparam int EV_WARN_ON = 0;
	localparam int EV_WARN_OFF = 1;
	localparam int EV_MOD_ERR = 2;
	localparam int EV_VIB_ALARM = 3;

endpackage : warn_pkg

// ===== warn_sync.sv
// per-bit three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module warn_sync
	import warn_pkg::*;
#(
	parameter int WIDTH = 1
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// raw and cleaned levels
	input wire logic [WIDTH-1:0] raw,
	output logic [WIDTH-1:0] clean
);

	typedef struct packed
	{
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] out;
	} sync_s;

	sync_s st_q;
	sync_s st_d;

	// first stage is read only by the second
	always_comb
	begin
		st_d = st_q;
		st_d.s1 = raw;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		for (int i = 0; i < WIDTH; i++)
		begin
			if (st_q.s2[i] == st_q.s3[i])
			begin
				st_d.out[i] = st_q.s3[i];
			end
		end
	end

	// frozen while the clock enable is low
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q <= '0;
		end
		else if (clk_en)
		begin
			st_q <= st_d;
		end
	end

	assign clean = st_q.out;

endmodule : warn_sync

// ===== warn_encoder.sv
// warning status encoder: code lines, warning output, indicator, query replies
//
// Summary of operation
// [R01] warnings never stop motor or remove power
// [R02] warning: query reply, warn out, flash led
// [R03] warnings leave last-error reply untouched
// [R04] code lines carry warnings only when selected
// [R05] detect-disable keeps only undervoltage warning; the module error warning still shows while its hold runs
// [R06] position error overflows: all lines open
// [R07] overload, vibration: line0 closed only
// [R08] regen, brake overload: line1 closed only
// [R09] battery low: line0, line1 closed
// [R10] data setting warnings: line2 closed only
// [R11] command warnings: line0, line2 closed
// [R12] option comm fault: line1, line2 closed
// [R13] undervoltage: all three lines closed
// [R14] module error: line0 closed only
// [R15] vibration reported as warning or alarm
// [R16] module error held two seconds, servo on
// [R17] code lines and warn change together
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
module warn_encoder
	import warn_pkg::*;
#(
	parameter int HOLD_CYCLES = HOLD_CYC,
	parameter int FLASH_CYCLES = FLASH_HALF_CYC
)
(
	// clock, reset, enable
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// warning causes from detection logic (asynchronous levels)
	input wire logic [NUM_WARN-1:0] warn_cause,
	// module error pulse from the option logic (same clock)
	input wire logic module_err,
	input wire logic [11:0] module_err_code,
	// alarm side, passed through untouched
	input wire logic alarm_in,
	input wire logic [2:0] alarm_code,
	input wire logic servo_on_req,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// pins
	output logic code_line_0,
	output logic code_line_1,
	output logic code_line_2,
	output logic warn_out,
	output logic alarm_flag_out,
	output logic led_red,
	output logic servo_power_en,
	output logic vib_alarm,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////
	// state

	typedef enum logic [1:0]
	{
		HOLD_IDLE = 2'b01,
		HOLD_ACT = 2'b10
	} hold_e;

	typedef struct packed
	{
		logic [2:0] config_r;    // software settings
		logic [3:0] status;      // sticky events
		logic [3:0] mask;        // interrupt mask
		logic [11:0] last_err;   // most recent error code
		logic [11:0] query;      // alarm/warning reply
		logic [2:0] lines;       // code lines, registered
		logic warn;              // warning output, registered
		logic alarm;             // alarm output
		logic led;               // flashing red indicator
		logic vib_alm;           // vibration raised as alarm
		logic [31:0] rdata;      // read data
		hold_e hold;             // module error hold state
		logic [31:0] hold_cnt;   // module error countdown
		logic [31:0] flash_cnt;  // indicator toggle countdown
		logic warn_prev;         // for edge events
	} enc_s;

	enc_s st_q;
	enc_s st_d;

	logic [NUM_WARN-1:0] cause_s;  // synchronised causes
	logic [NUM_WARN-1:0] cause_v;  // after detection gating
	logic [2:0] w_code;            // priority-encoded lines
	logic [11:0] w_qc;             // priority-encoded reply
	logic any_warn;

	////////////////////////////////////////////////////////////////////////
	// input synchronisers

	warn_sync #(
		.WIDTH(NUM_WARN)
	) u_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.raw(warn_cause),
		.clean(cause_s)
	);

	////////////////////////////////////////////////////////////////////////
	// detection gating and classification

	// disable keeps undervoltage alive; vibration drops out when sent as alarm
	always_comb
	begin
		cause_v = cause_s;
		if (st_q.config_r[CFG_DET_OFF])
		begin
			cause_v = '0;                                  // see [R05]
			cause_v[W_UNDERVOLT] = cause_s[W_UNDERVOLT];   // see [R05]
		end
		if (st_q.config_r[CFG_VIB_ALM])
			cause_v[W_VIBRATION] = 1'b0;                   // see [R15]
	end

	// priority: undervoltage first as it leads to a supply alarm, then by class
	always_comb
	begin
		w_code = CODE_NONE;
		w_qc = QC_NONE;
		for (int i = W_CMD0 + W_CMD_N - 1; i >= W_CMD0; i--)
		begin
			if (cause_v[i])
			begin
				w_code = CODE_CMD;                        // see [R11]
				w_qc = QC_CMD0 + 12'(i - W_CMD0) + ((i >= W_CMD0 + W_CMD_GAP) ? 12'h1 : 12'h0);
			end
		end
		for (int i = W_DATA_SET0 + W_DATA_SET_N - 1; i >= W_DATA_SET0; i--)
		begin
			if (cause_v[i])
			begin
				w_code = CODE_DATA;                       // see [R10]
				w_qc = QC_DATA0 + 12'(i - W_DATA_SET0);
			end
		end
		if (cause_v[W_COMM])
		begin
			w_code = CODE_COMM;                           // see [R12]
			w_qc = QC_COMM;
		end
		if (cause_v[W_BATTERY])
		begin
			w_code = CODE_BAT;                            // see [R09]
			w_qc = QC_BAT;
		end
		if (cause_v[W_DYN_BRAKE] || cause_v[W_REGEN])
		begin
			w_code = CODE_REG;                            // see [R08]
			w_qc = cause_v[W_REGEN] ? QC_REG : QC_DB;
		end
		if (cause_v[W_VIBRATION] || cause_v[W_OVERLOAD])
		begin
			w_code = CODE_OVL;                            // see [R07]
			w_qc = cause_v[W_OVERLOAD] ? QC_OVL : QC_VIB;
		end
		if (cause_v[W_POS_ERR_SON] || cause_v[W_POS_ERR])
		begin
			w_code = CODE_POS;                            // see [R06]
			w_qc = cause_v[W_POS_ERR] ? QC_POS : QC_POS_SON;
		end
		if (cause_v[W_UNDERVOLT])
		begin
			w_code = CODE_UV;                             // see [R13]
			w_qc = QC_UV;
		end
		if ((w_qc == QC_NONE) && (st_q.hold == HOLD_ACT))
		begin
			w_code = CODE_MOD;                            // see [R14]
			w_qc = QC_MOD;
		end
	end

	assign any_warn = (w_qc != QC_NONE);

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb
	begin
		st_d = st_q;
		st_d.rdata = '0;
		// module error hold, restarts on each new error
		case (st_q.hold)
			HOLD_IDLE:
			begin
				if (module_err)
				begin
					st_d.hold = HOLD_ACT;
					st_d.hold_cnt = 32'(HOLD_CYCLES - 1);   // see [R16]
				end
			end
			HOLD_ACT:
			begin
				if (module_err)
					st_d.hold_cnt = 32'(HOLD_CYCLES - 1);
				else if (st_q.hold_cnt == '0)
					st_d.hold = HOLD_IDLE;                   // see [R16]
				else
					st_d.hold_cnt = st_q.hold_cnt - 32'h1;
			end
			default:
				st_d.hold = HOLD_IDLE;
		endcase
		// errors only land in the last-error reply, never warnings
		if (module_err)
			st_d.last_err = module_err_code;             // see [R03]
		// lines and warning output update in the same edge
		st_d.warn = any_warn;                            // see [R02] [R17]
		st_d.query = alarm_in ? st_q.query : w_qc;       // see [R02]
		if (alarm_in)
			st_d.lines = alarm_code;                     // alarm owns the lines
		else if (st_q.config_r[CFG_CODE_SEL])
			st_d.lines = w_code;                         // see [R04] [R17]
		else
			st_d.lines = CODE_NONE;                      // see [R04]
		st_d.alarm = alarm_in;                           // see [R02]
		st_d.vib_alm = st_q.config_r[CFG_VIB_ALM] & cause_s[W_VIBRATION]; // see [R15]
		// indicator flashes while any warning stands
		if (!any_warn)
		begin
			st_d.led = 1'b0;
			st_d.flash_cnt = 32'(FLASH_CYCLES - 1);
		end
		else if (st_q.flash_cnt == '0)
		begin
			st_d.led = ~st_q.led;                        // see [R02]
			st_d.flash_cnt = 32'(FLASH_CYCLES - 1);
		end
		else
		begin
			st_d.flash_cnt = st_q.flash_cnt - 32'h1;
		end
		st_d.warn_prev = any_warn;
		// register writes
		if (reg_wr)
		begin
			if (reg_addr == A_CONFIG)
				st_d.config_r = reg_wdata[2:0];
			else if (reg_addr == A_MASK)
				st_d.mask = reg_wdata[3:0];
		end
		// register reads; a status read clears it
		if (reg_rd)
		begin
			if (reg_addr == A_CONFIG)
				st_d.rdata = {29'h0, st_q.config_r};
			else if (reg_addr == A_STATUS)
			begin
				st_d.rdata = {28'h0, st_q.status};
				st_d.status = '0;
			end
			else if (reg_addr == A_MASK)
				st_d.rdata = {28'h0, st_q.mask};
			else if (reg_addr == A_QUERY)
				st_d.rdata = {20'h0, st_q.query};
			else if (reg_addr == A_LAST_ERR)
				st_d.rdata = {20'h0, st_q.last_err};
			else if (reg_addr == A_LINES)
				st_d.rdata = {27'h0, st_q.warn, st_q.alarm, st_q.lines};
			else
				st_d.rdata = '0;                         // unmapped reads as zero
		end
		// event sets win over the read clear
		if (any_warn && !st_q.warn_prev)
			st_d.status[EV_WARN_ON] = 1'b1;
		if (!any_warn && st_q.warn_prev)
			st_d.status[EV_WARN_OFF] = 1'b1;
		if (module_err)
			st_d.status[EV_MOD_ERR] = 1'b1;
		if (st_d.vib_alm && !st_q.vib_alm)
			st_d.status[EV_VIB_ALARM] = 1'b1;
	end

	// one register stage for all state
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q <= '{config_r: CONFIG_RST, mask: MASK_RST, hold: HOLD_IDLE, default: '0};
		end
		else if (clk_en)
		begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign code_line_0 = st_q.lines[0];
	assign code_line_1 = st_q.lines[1];
	assign code_line_2 = st_q.lines[2];
	assign warn_out = st_q.warn;
	assign alarm_flag_out = st_q.alarm;
	assign led_red = st_q.led;
	assign vib_alarm = st_q.vib_alm;
	assign reg_rdata = st_q.rdata;
	assign irq = |(st_q.status & st_q.mask);
	// warnings have no path into power; only the alarm side drops it
	assign servo_power_en = servo_on_req & ~st_q.alarm; // see [R01]

	////////////////////////////////////////////////////////////////////////
	// checks

	a_warn_lines_sync: assert property (@(posedge core_clk) disable iff (!rst_n) // see [R17]
		clk_en && !alarm_in && st_q.config_r[CFG_CODE_SEL]
		|=> ({code_line_2, code_line_1, code_line_0} == $past(w_code)) && (warn_out == $past(any_warn)))
		else $error("code lines and warning output out of step");

	a_uv_all_on: assert property (@(posedge core_clk) disable iff (!rst_n) // see [R13]
		clk_en && !alarm_in && cause_s[W_UNDERVOLT] && st_q.config_r[CFG_CODE_SEL]
		|=> code_line_0 && code_line_1 && code_line_2)
		else $error("undervoltage code not all closed");

	a_detect_off: assert property (@(posedge core_clk) disable iff (!rst_n) // see [R05]
		st_q.config_r[CFG_DET_OFF] && !cause_s[W_UNDERVOLT] && st_q.hold == HOLD_IDLE
		|-> !any_warn)
		else $error("warning seen with detection disabled");

	a_pos_all_off: assert property (@(posedge core_clk) disable iff (!rst_n) // see [R06]
		clk_en && !alarm_in && (cause_v[W_POS_ERR] || cause_v[W_POS_ERR_SON]) && !cause_v[W_UNDERVOLT]
		|=> {code_line_2, code_line_1, code_line_0} == CODE_POS)
		else $error("position error code lines not open");

	a_code_gate: assert property (@(posedge core_clk) disable iff (!rst_n) // see [R04]
		clk_en && !alarm_in && !st_q.config_r[CFG_CODE_SEL]
		|=> {code_line_2, code_line_1, code_line_0} == CODE_NONE)
		else $error("warning code driven while not selected");

	a_servo_kept: assert property (@(posedge core_clk) disable iff (!rst_n) // see [R01]
		servo_on_req && !st_q.alarm |-> servo_power_en)
		else $error("warning removed servo power");

	a_last_err_kept: assert property (@(posedge core_clk) disable iff (!rst_n) // see [R03]
		clk_en && !module_err |=> $stable(st_q.last_err))
		else $error("last error changed without an error");

	a_hold_start: assert property (@(posedge core_clk) disable iff (!rst_n) // see [R16]
		clk_en && module_err |=> st_q.hold == HOLD_ACT && st_q.hold_cnt == 32'(HOLD_CYCLES - 1))
		else $error("module error hold not started");

	a_query_warn: assert property (@(posedge core_clk) disable iff (!rst_n) // see [R02]
		clk_en && !alarm_in && any_warn |=> warn_out && st_q.query == $past(w_qc))
		else $error("warning reply not posted");

	a_vib_route: assert property (@(posedge core_clk) disable iff (!rst_n) // see [R15]
		st_q.config_r[CFG_VIB_ALM] |-> !cause_v[W_VIBRATION])
		else $error("vibration reported as warning in alarm mode");

endmodule : warn_encoder

// ===== host_ctrl_model.sv
// host controller model: samples the coded warning lines as a host input card would
`timescale 1ns/1ns
module host_ctrl_model
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// discrete inputs from the drive
	input wire logic code_line_0,
	input wire logic code_line_1,
	input wire logic code_line_2,
	input wire logic warn_out,
	// latched view {warn, line2, line1, line0}
	output logic [3:0] host_view_q
);
	////////////////////////////////////////////////////////////////////////////
	// one sample per edge; a torn code would show up here as a mixed view
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			host_view_q <= 4'h0;
		else
			host_view_q <= {warn_out, code_line_2, code_line_1, code_line_0};
	end
endmodule : host_ctrl_model

// ===== servo_warning_status_encoder_test.sv
// testbench of the warning status encoder
`timescale 1ns/1ns
module servo_warning_status_encoder_test;
	import warn_pkg::*;
	////////////////////////////////////////////////////////////////////////////
	// stimulus and observed signals
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic [NUM_WARN-1:0] warn_cause = '0;
	logic module_err = 1'b0;
	logic [11:0] module_err_code = 12'h000;
	logic alarm_in = 1'b0;
	logic [2:0] alarm_code = 3'h0;
	logic servo_on_req = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic code_line_0, code_line_1, code_line_2;
	logic warn_out, alarm_flag_out, led_red, servo_power_en, vib_alarm, irq;
	logic [3:0] host_view_q;
	logic [31:0] rd;
	int fails = 0;
	int compares = 0;
	int cycles = 0;
	int led_hi;
	int led_lo;
	////////////////////////////////////////////////////////////////////////////
	// design and host model; short counts keep the run brief
	warn_encoder #(.HOLD_CYCLES(20), .FLASH_CYCLES(4)) uut (.core_clk(core_clk),
		.rst_n(rst_n), .clk_en(clk_en), .warn_cause(warn_cause), .module_err(module_err),
		.module_err_code(module_err_code), .alarm_in(alarm_in), .alarm_code(alarm_code),
		.servo_on_req(servo_on_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .code_line_0(code_line_0),
		.code_line_1(code_line_1), .code_line_2(code_line_2), .warn_out(warn_out),
		.alarm_flag_out(alarm_flag_out), .led_red(led_red), .servo_power_en(servo_power_en),
		.vib_alarm(vib_alarm), .irq(irq));
	host_ctrl_model host (.core_clk(core_clk), .rst_n(rst_n), .code_line_0(code_line_0),
		.code_line_1(code_line_1), .code_line_2(code_line_2), .warn_out(warn_out),
		.host_view_q(host_view_q));
	////////////////////////////////////////////////////////////////////////////
	// 50 MHz clock and hang guard
	always #10 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fails++;
			finish_test();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// helpers
	task check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fails++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task finish_test();
		if (fails == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finish_test
	// wait n edges, then sample where outputs have settled
	task wait_n(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : wait_n
	task reg_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : reg_write
	// read data stand only in the cycle after the strobe
	task reg_read(input logic [3:0] a);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		rd = reg_rdata;
	endtask : reg_read
	// causes pass three sync stages plus output registers
	task set_cause(input logic [NUM_WARN-1:0] v);
		@(posedge core_clk);
		warn_cause <= v;
		wait_n(8);
	endtask : set_cause
	function logic [3:0] lines();
		return {warn_out, code_line_2, code_line_1, code_line_0};
	endfunction : lines
	// expected code pattern {line2, line1, line0} per cause bit
	function logic [2:0] exp_code(input int i);
		if (i <= 1) return 3'h0;
		if (i <= 3) return 3'h1;
		if (i <= 5) return 3'h2;
		if (i == 6) return 3'h3;
		if (i <= 11) return 3'h4;
		if (i <= 16) return 3'h5;
		if (i == 17) return 3'h6;
		return 3'h7;
	endfunction : exp_code
	function automatic logic [11:0] exp_query(input int i);
		logic [11:0] t [NUM_WARN] = '{12'h900, 12'h901, 12'h910, 12'h911, 12'h920,
			12'h921, 12'h930, 12'h94A, 12'h94B, 12'h94C, 12'h94D, 12'h94E, 12'h95A,
			12'h95B, 12'h95D, 12'h95E, 12'h95F, 12'h960, 12'h971};
		return t[i];
	endfunction : exp_query
	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		wait_n(1);
		check(lines(), 4'h0);
		reg_read(A_CONFIG);
		check(rd, 32'h0);
		reg_read(A_MASK);
		check(rd, 32'h0);
		reg_read(4'hF);
		check(rd, 32'h0);
		// every warning class with codes enabled
		reg_write(A_CONFIG, 32'h1);
		for (int i = 0; i < NUM_WARN; i++)
		begin
			set_cause(NUM_WARN'(1) << i);
			check(lines(), {1'b1, exp_code(i)});
			check(host_view_q, {1'b1, exp_code(i)});
			check({servo_power_en, alarm_flag_out}, 2'h2);
			reg_read(A_QUERY);
			check(rd, {20'h0, exp_query(i)});
			set_cause('0);
			check(lines(), 4'h0);
		end
		reg_read(A_LAST_ERR);
		check(rd, 32'h0);
		// flashing indicator while a warning stands
		set_cause(NUM_WARN'(1) << W_UNDERVOLT);
		led_hi = 0;
		led_lo = 0;
		repeat (12)
		begin
			wait_n(1);
			if (led_red === 1'b1) led_hi++;
			if (led_red === 1'b0) led_lo++;
		end
		check(led_hi > 0 && led_lo > 0, 1'b1);
		set_cause('0);
		check(led_red, 1'b0);
		// codes withheld when not selected
		reg_write(A_CONFIG, 32'h0);
		set_cause(NUM_WARN'(1) << W_OVERLOAD);
		check(lines(), 4'h8);
		// detection off: the overload still standing must vanish
		reg_write(A_CONFIG, 32'h3);
		wait_n(4);
		check(lines(), 4'h0);
		set_cause(NUM_WARN'(1) << W_UNDERVOLT | NUM_WARN'(1) << W_OVERLOAD);
		check(lines(), 4'hF);
		set_cause('0);
		// vibration routed as alarm
		reg_write(A_CONFIG, 32'h5);
		set_cause(NUM_WARN'(1) << W_VIBRATION);
		check({vib_alarm, warn_out}, 2'h2);
		set_cause('0);
		// interrupt raise, clear by read, then masked
		reg_write(A_CONFIG, 32'h1);
		reg_write(A_MASK, 32'h1);
		reg_read(A_STATUS);
		set_cause(NUM_WARN'(1) << W_BATTERY);
		check(irq, 1'b1);
		reg_read(A_STATUS);
		check(rd[0], 1'b1);
		check(irq, 1'b0);
		reg_write(A_MASK, 32'h0);
		set_cause('0);
		check(irq, 1'b0);
		reg_read(A_STATUS);
		check(rd[1:0], 2'h2);
		// module error: held, then released, servo kept on
		@(posedge core_clk);
		module_err <= 1'b1;
		module_err_code <= 12'hE41;
		@(posedge core_clk);
		module_err <= 1'b0;
		wait_n(8);
		check(lines(), 4'h9);
		check(servo_power_en, 1'b1);
		reg_read(A_LAST_ERR);
		check(rd, 32'hE41);
		// last cycle of the hold, then released on the next edge
		wait_n(10);
		check(lines(), 4'h9);
		wait_n(1);
		check(lines(), 4'h0);
		// clock enable low freezes the lines against a cause change
		set_cause(NUM_WARN'(1) << W_COMM);
		@(posedge core_clk);
		clk_en <= 1'b0;
		warn_cause <= '0;
		wait_n(8);
		check(lines(), 4'hE);
		@(posedge core_clk);
		clk_en <= 1'b1;
		wait_n(8);
		check(lines(), 4'h0);
		// alarm passes through, code shows alarm pattern
		@(posedge core_clk);
		alarm_in <= 1'b1;
		alarm_code <= 3'h5;
		wait_n(4);
		check({alarm_flag_out, servo_power_en, lines()}, 6'h25);
		reg_read(A_LINES);
		check(rd, 32'h0000000D);
		@(posedge core_clk);
		alarm_in <= 1'b0;
		wait_n(4);
		finish_test();
	end
endmodule : servo_warning_status_encoder_test
